//--- design/bpas_defines.vh
/*
 * Constants for the bus privilege attribute staging block: register
 * offsets, field positions, reset values and privilege encodings.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef BPAS_DEFINES_VH
`define BPAS_DEFINES_VH

// apb register byte offsets
`define BPAS_OFF_CTRL      12'h000
`define BPAS_OFF_STATUS    12'h004
`define BPAS_OFF_ERR_ADDR  12'h008
`define BPAS_OFF_ERR_CAP   12'h00C

// control register fields
`define BPAS_CTRL_STAGE_BIT   0
`define BPAS_CTRL_CLR_BIT     1
`define BPAS_CTRL_RST         2'h1

// error capture fields
`define BPAS_CAP_SUP_BIT      0
`define BPAS_CAP_WR_BIT       1
`define BPAS_CAP_SIZE_LSB     2
`define BPAS_CAP_VALID_BIT    4

// status fields
`define BPAS_ST_SBUF_BIT      0
`define BPAS_ST_LD_BIT        1
`define BPAS_ST_PRIV_LSB      2
`define BPAS_ST_MIS_BIT       4

// io privilege field encodings
`define BPAS_IO_USER0         2'h0
`define BPAS_IO_USER1         2'h1
`define BPAS_IO_SUPER         2'h2

`endif

//--- design/bpas_top.v
/*
 * Bus privilege attribute staging: tags each core load/store bus
 * transaction with address, size, direction and a user/supervisor flag,
 * holds one buffered store, and captures the privilege of failing
 * transfers for software.
 * Assumes a single core clock, core handshakes synchronous to it, and
 * an apb master on the register port.
 */
// Implementation choices: the APB interface to the registers and the address map.
// Function
// - bus transaction address and size come from the issuing instruction
// - each transaction carries a user or supervisor flag from io privilege field
// - legacy mode samples current io privilege field when store reaches bus
// - legacy mode lets buffered supervisor store go out tagged user
// - both user sub-levels map to the one user indication
// - loads block until done, never outstanding across privilege change
// - user level code cannot write the program status word
// - error capture bit: 0 user initiated, 1 supervisor initiated
`timescale 1ns/10ps
`include "bpas_defines.vh"

module bpas_top #(
  parameter AW = 32,
  parameter DW = 32
) (
  input  wire          mclk_i,
  input  wire          rst_i,
  // core load/store request
  input  wire          req_valid_i,
  input  wire          req_write_i,
  input  wire [AW-1:0] req_addr_i,
  input  wire [1:0]    req_size_i,
  input  wire [DW-1:0] req_wdata_i,
  output reg           req_ready_o,
  output reg           ld_done_o,
  output reg  [DW-1:0] ld_rdata_o,
  // program status word write
  input  wire          psw_wr_i,
  input  wire [1:0]    io_privilege_field_wdata_i,
  output reg  [1:0]    io_privilege_field_o,
  // system bus master side
  output reg           bus_valid_o,
  output reg           bus_write_o,
  output reg  [AW-1:0] bus_addr_o,
  output reg  [1:0]    bus_size_o,
  output reg  [DW-1:0] bus_wdata_o,
  output reg           bus_super_o,
  input  wire          bus_done_i,
  input  wire          bus_err_i,
  input  wire [DW-1:0] bus_rdata_i,
  // apb slave
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [11:0]   paddr_i,
  input  wire [31:0]   pwdata_i,
  output reg  [31:0]   prdata_o,
  output reg           pready_o,
  output reg           pslverr_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_STOR = 2'h2;

  function is_super;
    input [1:0] io;
    begin
      is_super = (io == `BPAS_IO_SUPER);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////

  reg [1:0]    state_r;
  reg          sb_full_r;
  reg [AW-1:0] sb_addr_r;
  reg [1:0]    sb_size_r;
  reg [DW-1:0] sb_data_r;
  reg          sb_super_r;
  reg          stage_en_r;
  reg          mis_r;
  reg [AW-1:0] err_addr_r;
  reg          err_super_r;
  reg          err_wr_r;
  reg [1:0]    err_size_r;
  reg          err_valid_r;

  wire apb_acc = psel_i & penable_i & ~pready_o;
  wire apb_wr  = apb_acc & pwrite_i;
  wire ctrl_wr = apb_wr & (paddr_i == `BPAS_OFF_CTRL);
  wire err_clr = ctrl_wr & pwdata_i[`BPAS_CTRL_CLR_BIT];
  wire err_hit = bus_valid_o & bus_done_i & bus_err_i;
  wire cur_sup = is_super(io_privilege_field_o);
  // staged flag vs live field; legacy mode reproduces the original hazard
  wire st_sup  = stage_en_r ? sb_super_r : cur_sup;
  wire drain   = (state_r == ST_IDLE) & sb_full_r;
  wire take    = (state_r == ST_IDLE) & ~sb_full_r & req_valid_i & ~req_ready_o;
  wire ld_fin  = (state_r == ST_LOAD) & bus_done_i;
  // only the legacy path can misattribute; staged stores keep their tag
  wire mis_set = drain & ~stage_en_r & sb_super_r & ~cur_sup;

  reg  [31:0]  rd_nxt;
  reg          perr_nxt;

  ////////////////////////////////////////////////////////////////////////
  // privilege field: only supervisor code may rewrite it

  always @(posedge mclk_i) begin
    if (rst_i) begin
      io_privilege_field_o <= `BPAS_IO_SUPER;
    end else if (psw_wr_i && cur_sup) begin
      io_privilege_field_o <= io_privilege_field_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control: stage enable resets on, so the legacy hazard is opt-in

  always @(posedge mclk_i) begin
    if (rst_i) begin
      stage_en_r <= 1'b1;
    end else if (ctrl_wr) begin
      stage_en_r <= pwdata_i[`BPAS_CTRL_STAGE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-entry store buffer; attributes latched when the store executes

  always @(posedge mclk_i) begin
    if (rst_i) begin
      sb_full_r  <= 1'b0;
      sb_addr_r  <= {AW{1'b0}};
      sb_size_r  <= 2'h0;
      sb_data_r  <= {DW{1'b0}};
      sb_super_r <= 1'b0;
    end else if (take && req_write_i) begin
      sb_full_r  <= 1'b1;
      sb_addr_r  <= req_addr_i;
      sb_size_r  <= req_size_i;
      sb_data_r  <= req_wdata_i;
      sb_super_r <= cur_sup;
    end else if (state_r == ST_STOR && bus_done_i) begin
      sb_full_r  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load/store sequencing towards the system bus

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      req_ready_o <= 1'b0;
      bus_valid_o <= 1'b0;
      bus_write_o <= 1'b0;
      bus_addr_o  <= {AW{1'b0}};
      bus_size_o  <= 2'h0;
      bus_wdata_o <= {DW{1'b0}};
      bus_super_o <= 1'b0;
    end else begin
      req_ready_o <= take;
      case (state_r)
        ST_IDLE: begin
          if (drain) begin
            // drain buffered store first; tag chosen here by stage mode
            bus_valid_o <= 1'b1;
            bus_write_o <= 1'b1;
            bus_addr_o  <= sb_addr_r;
            bus_size_o  <= sb_size_r;
            bus_wdata_o <= sb_data_r;
            bus_super_o <= st_sup;
            state_r     <= ST_STOR;
          end else if (take && !req_write_i) begin
            // load goes out at once and blocks the core
            bus_valid_o <= 1'b1;
            bus_write_o <= 1'b0;
            bus_addr_o  <= req_addr_i;
            bus_size_o  <= req_size_i;
            bus_super_o <= cur_sup;
            state_r     <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (bus_done_i) begin
            bus_valid_o <= 1'b0;
            state_r     <= ST_IDLE;
          end
        end
        ST_STOR: begin
          if (bus_done_i) begin
            bus_valid_o <= 1'b0;
            state_r     <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load return: data held until the next load completes

  always @(posedge mclk_i) begin
    if (rst_i) begin
      ld_done_o  <= 1'b0;
      ld_rdata_o <= {DW{1'b0}};
    end else begin
      ld_done_o <= ld_fin;
      if (ld_fin) begin
        ld_rdata_o <= bus_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error capture; a failing transfer in the clear cycle wins over clear

  always @(posedge mclk_i) begin
    if (rst_i) begin
      err_valid_r <= 1'b0;
      err_addr_r  <= {AW{1'b0}};
      err_super_r <= 1'b0;
      err_wr_r    <= 1'b0;
      err_size_r  <= 2'h0;
    end else if (err_hit) begin
      err_valid_r <= 1'b1;
      err_addr_r  <= bus_addr_o;
      err_super_r <= bus_super_o;
      err_wr_r    <= bus_write_o;
      err_size_r  <= bus_size_o;
    end else if (err_clr) begin
      err_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // misattribution seen: legacy drain of a supervisor store while user

  always @(posedge mclk_i) begin
    if (rst_i) begin
      mis_r <= 1'b0;
    end else if (mis_set) begin
      mis_r <= 1'b1;
    end else if (err_clr) begin
      mis_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read word and error response, registered below

  always @* begin
    rd_nxt   = 32'h0000_0000;
    perr_nxt = 1'b0;
    case (paddr_i)
      `BPAS_OFF_CTRL: begin
        rd_nxt[`BPAS_CTRL_STAGE_BIT] = stage_en_r;
      end
      `BPAS_OFF_STATUS: begin
        rd_nxt[`BPAS_ST_SBUF_BIT] = sb_full_r;
        rd_nxt[`BPAS_ST_LD_BIT]   = (state_r == ST_LOAD);
        rd_nxt[`BPAS_ST_PRIV_LSB+1:`BPAS_ST_PRIV_LSB] = io_privilege_field_o;
        rd_nxt[`BPAS_ST_MIS_BIT]  = mis_r;
        perr_nxt = pwrite_i;
      end
      `BPAS_OFF_ERR_ADDR: begin
        rd_nxt   = err_addr_r[31:0];
        perr_nxt = pwrite_i;
      end
      `BPAS_OFF_ERR_CAP: begin
        rd_nxt[`BPAS_CAP_SUP_BIT]   = err_super_r;
        rd_nxt[`BPAS_CAP_WR_BIT]    = err_wr_r;
        rd_nxt[`BPAS_CAP_SIZE_LSB+1:`BPAS_CAP_SIZE_LSB] = err_size_r;
        rd_nxt[`BPAS_CAP_VALID_BIT] = err_valid_r;
        perr_nxt = pwrite_i;
      end
      default: begin
        perr_nxt = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  always @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= apb_acc;
      pslverr_o <= apb_acc & perr_nxt;
      prdata_o  <= apb_acc ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule // bpas_top

//--- sim/bpas_top_properties.sv
/* Checker on bpas_top ports: transfer attributes, privilege tag, load
   completion and status word lock. Bound into every bpas_top. */
`timescale 1ns/10ps
module bpas_top_checker #(parameter AW = 32, parameter DW = 32) (
  input logic          mclk_i, rst_i, req_write_i, req_ready_o, ld_done_o, psw_wr_i,
  input logic          bus_valid_o, bus_write_o, bus_super_o, bus_done_i,
  input logic [1:0]    req_size_i, io_privilege_field_wdata_i, io_privilege_field_o, bus_size_o,
  input logic [AW-1:0] req_addr_i, bus_addr_o,
  input logic [DW-1:0] ld_rdata_o, bus_rdata_i, req_wdata_i, bus_wdata_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////
  chk_load_attr: assert property (req_ready_o && !req_write_i |-> bus_valid_o &&
    bus_addr_o == req_addr_i && bus_size_o == req_size_i) else $error("load attr");
  chk_store_drain: assert property (req_ready_o && req_write_i |=> bus_valid_o &&
    bus_write_o && bus_addr_o == $past(req_addr_i)) else $error("store drain");
  chk_bus_hold: assert property (bus_valid_o && !bus_done_i |=> bus_valid_o &&
    $stable(bus_addr_o) && $stable(bus_super_o)) else $error("bus hold");
  chk_load_priv: assert property (req_ready_o && !req_write_i |->
    bus_super_o == ($past(io_privilege_field_o) == 2'h2)) else $error("load priv");
  chk_store_data: assert property (req_ready_o && req_write_i |=>
    bus_wdata_o == $past(req_wdata_i)) else $error("store data");
  chk_load_done: assert property (bus_valid_o && !bus_write_o && bus_done_i |=>
    ld_done_o && ld_rdata_o == $past(bus_rdata_i)) else $error("load done");
  chk_load_block: assert property (req_ready_o && !req_write_i |=>
    !req_ready_o [*2]) else $error("load overlap");
  chk_user_lock: assert property (io_privilege_field_o != 2'h2 |=>
    $stable(io_privilege_field_o)) else $error("user lock");
  chk_psw_apply: assert property (psw_wr_i && io_privilege_field_o == 2'h2 |=>
    io_privilege_field_o == $past(io_privilege_field_wdata_i)) else $error("psw apply");
  cover property (bus_valid_o && bus_write_o && !bus_super_o);
  cover property (psw_wr_i && io_privilege_field_o != 2'h2);
  cover property (ld_done_o);
endmodule // bpas_top_checker
bind bpas_top bpas_top_checker #(.AW(AW), .DW(DW)) u_chk (.*);

//--- sim/bpas_bus_slave.sv
/* Far-side bus slave: answers after lat_i wait cycles, errs on fail_i,
   keeps the privilege of the last store in sup_o. Assumes held requests. */
`timescale 1ns/10ps
module bpas_bus_slave (
  input  logic        clk_i, rst_i, valid_i, write_i, super_i, fail_i,
  input  logic [3:0]  lat_i,
  input  logic [31:0] addr_i,
  output logic        done_o, err_o, sup_o,
  output logic [31:0] rdata_o
);
  logic [3:0] cnt_r;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    err_o <= 1'b0;
    rdata_o <= ~rdata_o; // stale data must never look valid
    if (rst_i) begin
      cnt_r <= 4'h0;
      rdata_o <= 32'h0;
      sup_o <= 1'b0;
    end else if (valid_i && !done_o) begin
      cnt_r <= (cnt_r == lat_i) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == lat_i) begin
        done_o <= 1'b1;
        err_o <= fail_i;
        rdata_o <= addr_i ^ 32'h5A5A5A5A;
        if (write_i) sup_o <= super_i;
      end
    end
  end
endmodule // bpas_bus_slave

//--- sim/bpas_top_test.sv
/* Bench for bpas_top: apb registers, core loads and stores, status word
   writes, against the slave model. Assumes a 20 MHz clock. */
`timescale 1ns/10ps
module bpas_top_test;
  logic mclk_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, psw_wr_i = 0, psel_i = 0;
  logic penable_i = 0, pwrite_i = 0, fail = 0, sup, req_ready_o, ld_done_o, bus_valid_o;
  logic bus_write_o, bus_super_o, bus_done_i, bus_err_i, pready_o, pslverr_o;
  logic [1:0] req_size_i = 0, io_privilege_field_wdata_i = 0, io_privilege_field_o, bus_size_o;
  logic [3:0] lat = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] req_addr_i = 0, req_wdata_i = 0, pwdata_i = 0, bus_rdata_i, ld_rdata_o;
  logic [31:0] bus_addr_o, bus_wdata_o, prdata_o;
  int fails = 0, total_checks = 0;
  bpas_top uut (.*);
  bpas_bus_slave u_slave (.clk_i(mclk_i), .rst_i, .valid_i(bus_valid_o), .write_i(bus_write_o),
    .super_i(bus_super_o), .fail_i(fail), .lat_i(lat), .addr_i(bus_addr_o),
    .done_o(bus_done_i), .err_o(bus_err_i), .sup_o(sup), .rdata_o(bus_rdata_i));
  always #25 mclk_i = ~mclk_i;
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] a, input logic [31:0] x);
    total_checks++;
    if (a !== x) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, a, x);
    end
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic x);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i) penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk({31'h0, pslverr_o}, {31'h0, x});
    if (!w && !x) chk(prdata_o, d);
    @(posedge mclk_i);
  endtask
  task core(input logic w, input logic [31:0] a, input logic [1:0] s);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_size_i <= s;
    req_wdata_i <= ~a;
    do @(posedge mclk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    psw_wr_i <= 1'b0;
    do @(posedge mclk_i); while ((w ? bus_done_i : ld_done_o) !== 1'b1);
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge mclk_i);
    fails++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    acc(1'b0, 12'h004, 32'h8, 1'b0);
    acc(1'b0, 12'h010, 32'h0, 1'b1);
    acc(1'b1, 12'h004, 32'h0, 1'b1);
    $display("test 1 done");
    for (int s = 0; s < 4; s++) begin
      lat <= s[3:0];
      core(1'b0, 32'h100 + 32'(s << 2), s[1:0]);
      chk(ld_rdata_o, (32'h100 + 32'(s << 2)) ^ 32'h5A5A5A5A);
    end
    fail <= 1'b1;
    core(1'b0, 32'h80, 2'h2);
    fail <= 1'b0;
    acc(1'b0, 12'h00C, 32'h19, 1'b0);
    acc(1'b0, 12'h008, 32'h80, 1'b0);
    acc(1'b1, 12'h000, 32'h3, 1'b0);
    $display("test 2 done");
    // staged: store taken in supervisor, field drops to user alongside
    psw_wr_i <= 1'b1;
    core(1'b1, 32'h200, 2'h2);
    chk({31'h0, sup}, 32'h1);
    psw_wr_i <= 1'b1;
    io_privilege_field_wdata_i <= 2'h2;
    @(posedge mclk_i) psw_wr_i <= 1'b0;
    @(posedge mclk_i) chk({30'h0, io_privilege_field_o}, 32'h0);
    fail <= 1'b1;
    core(1'b0, 32'h44, 2'h1);
    fail <= 1'b0;
    acc(1'b0, 12'h00C, 32'h14, 1'b0);
    acc(1'b0, 12'h004, 32'h0, 1'b0);
    $display("test 3 done");
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    acc(1'b1, 12'h000, 32'h0, 1'b0);
    psw_wr_i <= 1'b1;
    io_privilege_field_wdata_i <= 2'h1;
    core(1'b1, 32'h300, 2'h2);
    chk({31'h0, sup}, 32'h0);
    acc(1'b0, 12'h004, 32'h14, 1'b0);
    acc(1'b1, 12'h000, 32'h2, 1'b0);
    acc(1'b0, 12'h004, 32'h4, 1'b0);
    $display("test 4 done");
    end_of_test;
  end
endmodule // bpas_top_test
